/* File: efwec_pkg.sv */
package efwec_pkg;

    // Special function register addresses
    localparam logic [7:0] ADDR_ERASE_TRIGGER = 8'h94;
    localparam logic [7:0] ADDR_FLASH_CTRL = 8'hb2;
    localparam logic [7:0] ADDR_ERASE_PAGE = 8'hb7;

    // Configuration space addresses
    localparam logic [15:0] ADDR_ENGINE_ENABLE = 16'h2106;
    localparam logic [15:0] ADDR_ENGINE_CODE_LOC = 16'h2109;
    localparam logic [15:0] ADDR_WRITE_UNLOCK = 16'h2702;

    // Field positions
    localparam int CTRL_SELECT_BIT = 0;
    localparam int CTRL_MASS_EN_BIT = 1;
    localparam int CTRL_PENDING_BIT = 3;
    localparam int PAGE_LSB = 2;
    localparam int PAGE_MSB = 7;
    localparam int UNLOCK_LSB = 4;
    localparam int UNLOCK_MSB = 7;
    localparam int ENGINE_ENABLE_BIT = 0;

    // Keys, patterns and values
    localparam logic [3:0] UNLOCK_KEY = 4'h2;
    localparam logic [7:0] MASS_ERASE_PATTERN = 8'haa;
    localparam logic [7:0] PAGE_ERASE_PATTERN = 8'h55;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // Flash geometry
    localparam int FLASH_ADDR_W = 17;
    localparam int LOC_W = 7;
    localparam logic [6:0] LOC_MASK_SMALL = 7'h3f;
    localparam logic [6:0] LOC_MASK_LARGE = 7'h7f;
    localparam int LOC_SHIFT = 10;
    localparam int PAGE_SHIFT = 10;
    localparam int ENGINE_MAX_WORDS = 4096;
    localparam int ENGINE_PC_W = 12;

    // Flash command kinds
    typedef enum logic [1:0] {EFWEC_CMD_WRITE, EFWEC_CMD_PAGE, EFWEC_CMD_MASS} efwec_cmd_t;

    // Flash port owner codes
    localparam logic [1:0] OWN_MPU = 2'h0;
    localparam logic [1:0] OWN_ENGINE = 2'h1;
    localparam logic [1:0] OWN_SPI = 2'h2;
    localparam logic [1:0] OWN_SEQ = 2'h3;

endpackage : efwec_pkg

/* File: efwec_flash_arbiter.sv */
`timescale 1ns/1ns
module efwec_flash_arbiter (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic spi_ok,
    input wire logic key_ok,
    input wire logic spi_rd,
    input wire logic spi_wr,
    input wire logic spi_erase,
    input wire logic spi_erase_all,
    input wire logic [16:0] spi_addr,
    input wire logic [7:0] spi_wdata,
    input wire logic seq_valid,
    input wire efwec_pkg::efwec_cmd_t seq_kind,
    input wire logic [16:0] seq_addr,
    input wire logic [7:0] seq_wdata,
    input wire logic flash_busy,
    input wire logic ce_rd,
    input wire logic [16:0] ce_addr,
    input wire logic mpu_rd,
    input wire logic [16:0] mpu_addr,
    output logic seq_accept,
    output logic [16:0] fl_addr,
    output logic [7:0] fl_wdata,
    output logic fl_rd,
    output logic fl_wr,
    output logic fl_page_erase,
    output logic fl_mass_erase,
    output logic [1:0] fl_owner
);

    ////////////////////////////////////////////////////////////////////////////
    // Priority: SPI, sequencer, engine, MPU
    wire spi_req = spi_ok && (spi_rd || spi_wr || spi_erase);
    wire spi_mod_ok = key_ok && !flash_busy;
    assign seq_accept = seq_valid && !spi_req && !flash_busy;
    wire ce_sel = !spi_req && !seq_accept && ce_rd;
    wire mpu_sel = !spi_req && !seq_accept && !ce_rd && mpu_rd;
    wire [1:0] next_owner = spi_req ? efwec_pkg::OWN_SPI :
                            seq_accept ? efwec_pkg::OWN_SEQ :
                            ce_sel ? efwec_pkg::OWN_ENGINE : efwec_pkg::OWN_MPU;
    wire [16:0] next_addr = spi_req ? spi_addr : seq_accept ? seq_addr :
                            ce_sel ? ce_addr : mpu_addr;
    wire next_rd = (spi_req && spi_rd) || ce_sel || mpu_sel;
    wire next_wr = (spi_req && spi_wr && spi_mod_ok) ||
                   (seq_accept && seq_kind == efwec_pkg::EFWEC_CMD_WRITE);
    wire next_page = (spi_req && spi_erase && !spi_erase_all && spi_mod_ok) ||
                     (seq_accept && seq_kind == efwec_pkg::EFWEC_CMD_PAGE);
    wire next_mass = (spi_req && spi_erase && spi_erase_all && spi_mod_ok) ||
                     (seq_accept && seq_kind == efwec_pkg::EFWEC_CMD_MASS);

    // Registered flash port
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            fl_addr <= 17'h00000;
            fl_wdata <= 8'h00;
            fl_rd <= 1'b0;
            fl_wr <= 1'b0;
            fl_page_erase <= 1'b0;
            fl_mass_erase <= 1'b0;
            fl_owner <= 2'h0;
        end
        else
        begin
            fl_addr <= next_addr;
            fl_wdata <= spi_req ? spi_wdata : seq_wdata;
            fl_rd <= next_rd;
            fl_wr <= next_wr;
            fl_page_erase <= next_page;
            fl_mass_erase <= next_mass;
            fl_owner <= next_owner;
        end
    end

    // SPI never touches flash outside special flash mode
    property p_spi_only_in_mode;
        @(posedge clock) disable iff (!reset_n)
        !spi_ok |=> fl_owner != efwec_pkg::OWN_SPI;
    endproperty
    a_spi_only_in_mode: assert property (p_spi_only_in_mode)
        else $error("SPI owns flash outside special flash mode");

endmodule : efwec_flash_arbiter

/* File: efwec_flash_control.sv */
`timescale 1ns/1ns
// Summary of operation
// - Engine program region spans at most 4096 sixteen-bit words, 8 KB.
// - Engine first fetch address is 1024 times the code-location field.
// - Code-location field lives at 0x2109; 6 bits small, 7 bits large variant.
// - MPU reads any time; MPU erase only with engine off, writes with engine on are held to pass end; engine reads.
// - SPI gets flash access only in special flash mode with MPU halted.
// - MPU flash writes act only with the correct unlock key at 0x2702[7:4].
// - Only key 0010 is valid; any other blocks all writes and erases.
// - Select bit 0xB2[0] routes data stores to flash, else to data RAM.
// - Hardware clears the select bit after each flash byte write.
// - Software writes to the select bit are ignored while interrupts enabled.
// - With engine on, write waits for pass end; pending bit 0xB2[3] high.
// - Engine-busy falling edge clears pending and performs the held write.
// - Further flash writes are discarded while pending is high.
// - Erased bytes read 0xFF; erase covers a page or whole array only.
// - Erase starts only on the exact register pattern and order.
// - Mass erase: set bit 0xB2[1], then write 0xAA to 0x94.
// - Mass erase is refused unless the emulation port is enabled; the SPI mass erase path in the arbiter does not check it.
// - Page erase: page number to 0xB7[7:2], then 0x55 to 0x94.
module efwec_flash_control (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic large_variant,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    input wire logic [15:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    output logic [7:0] cfg_rdata,
    input wire logic interrupts_enabled,
    input wire logic store_wr,
    input wire logic [15:0] store_addr,
    input wire logic [7:0] store_data,
    output logic data_ram_wr,
    output logic [15:0] data_ram_addr,
    output logic [7:0] data_ram_wdata,
    input wire logic engine_busy,
    input wire logic ce_rd,
    input wire logic [11:0] ce_pc,
    input wire logic mpu_rd,
    input wire logic [15:0] mpu_rd_addr,
    input wire logic emulation_port,
    input wire logic special_flash_mode,
    input wire logic mpu_halted,
    input wire logic spi_rd,
    input wire logic spi_wr,
    input wire logic spi_erase,
    input wire logic spi_erase_all,
    input wire logic [16:0] spi_addr,
    input wire logic [7:0] spi_wdata,
    input wire logic flash_busy,
    output logic [16:0] flash_addr,
    output logic [7:0] flash_wdata,
    output logic flash_rd,
    output logic flash_wr,
    output logic flash_page_erase,
    output logic flash_mass_erase,
    output logic [1:0] flash_owner,
    output logic engine_enable
);

    ////////////////////////////////////////////////////////////////////////////
    // Register state
    logic flash_write_select;
    logic mass_erase_enable;
    logic posted_write_pending;
    logic [5:0] erase_page_number;
    logic page_armed;
    logic [3:0] write_unlock_key;
    logic [6:0] engine_code_location;
    logic engine_busy_q;
    logic cmd_valid;
    efwec_pkg::efwec_cmd_t cmd_kind;
    logic [16:0] cmd_addr;
    logic [7:0] cmd_data;
    logic seq_accept;

    ////////////////////////////////////////////////////////////////////////////
    // Decodes
    wire wr_ctrl = sfr_wr && sfr_addr == efwec_pkg::ADDR_FLASH_CTRL;
    wire wr_page = sfr_wr && sfr_addr == efwec_pkg::ADDR_ERASE_PAGE;
    wire wr_trig = sfr_wr && sfr_addr == efwec_pkg::ADDR_ERASE_TRIGGER;
    wire wr_en = cfg_wr && cfg_addr == efwec_pkg::ADDR_ENGINE_ENABLE;
    wire wr_loc = cfg_wr && cfg_addr == efwec_pkg::ADDR_ENGINE_CODE_LOC;
    wire wr_key = cfg_wr && cfg_addr == efwec_pkg::ADDR_WRITE_UNLOCK;
    wire key_ok = write_unlock_key == efwec_pkg::UNLOCK_KEY;
    wire seq_busy = cmd_valid || flash_busy;
    wire busy_fell = engine_busy_q && !engine_busy;

    // Code location masked per variant
    wire [6:0] loc_mask = large_variant ? efwec_pkg::LOC_MASK_LARGE :
                                          efwec_pkg::LOC_MASK_SMALL;
    wire [6:0] next_location = cfg_wdata[6:0] & loc_mask;

    // Engine fetch address
    wire [16:0] ce_base = {engine_code_location, 10'h000};
    wire [16:0] ce_offset = {4'h0, ce_pc, 1'b0};
    wire [16:0] ce_addr = ce_base + ce_offset;

    // Store routing
    wire store_flash = store_wr && flash_write_select;
    wire store_ram = store_wr && !flash_write_select;
    wire store_take = store_flash && key_ok && !posted_write_pending && !seq_busy;
    wire store_post = store_take && engine_enable;
    wire store_now = store_take && !engine_enable;

    // Erase triggers
    wire erase_ok = key_ok && !engine_enable && !seq_busy && !posted_write_pending;
    wire mass_go = wr_trig && sfr_wdata == efwec_pkg::MASS_ERASE_PATTERN &&
                   mass_erase_enable && emulation_port && erase_ok;
    wire page_go = wr_trig && sfr_wdata == efwec_pkg::PAGE_ERASE_PATTERN &&
                   page_armed && !mass_erase_enable && erase_ok;
    wire [16:0] page_base = 17'(erase_page_number) << efwec_pkg::PAGE_SHIFT;

    ////////////////////////////////////////////////////////////////////////////
    // Flash control and erase page register bits
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            flash_write_select <= 1'b0;
            mass_erase_enable <= 1'b0;
            page_armed <= 1'b0;
            erase_page_number <= 6'h00;
        end
        else
        begin
            if (store_flash)
                flash_write_select <= 1'b0;
            else if (wr_ctrl && !interrupts_enabled)
                flash_write_select <= sfr_wdata[efwec_pkg::CTRL_SELECT_BIT];
            if (wr_trig)
                mass_erase_enable <= 1'b0;
            else if (wr_ctrl)
                mass_erase_enable <= sfr_wdata[efwec_pkg::CTRL_MASS_EN_BIT];
            if (wr_trig)
                page_armed <= 1'b0;
            else if (wr_page)
                page_armed <= 1'b1;
            if (wr_page)
                erase_page_number <= sfr_wdata[efwec_pkg::PAGE_MSB:efwec_pkg::PAGE_LSB];
        end
    end

    // Configuration fields
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            write_unlock_key <= 4'h0;
            engine_code_location <= 7'h00;
            engine_enable <= 1'b0;
        end
        else
        begin
            if (wr_key)
                write_unlock_key <= cfg_wdata[efwec_pkg::UNLOCK_MSB:efwec_pkg::UNLOCK_LSB];
            if (wr_loc)
                engine_code_location <= next_location;
            if (wr_en)
                engine_enable <= cfg_wdata[efwec_pkg::ENGINE_ENABLE_BIT];
        end
    end

    // Posted write and the held command
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            engine_busy_q <= 1'b0;
            posted_write_pending <= 1'b0;
            cmd_valid <= 1'b0;
            cmd_kind <= efwec_pkg::EFWEC_CMD_WRITE;
            cmd_addr <= 17'h00000;
            cmd_data <= 8'h00;
        end
        else
        begin
            engine_busy_q <= engine_busy;
            if (store_post)
                posted_write_pending <= 1'b1;
            else if (busy_fell)
                posted_write_pending <= 1'b0;
            if (store_take)
            begin
                cmd_kind <= efwec_pkg::EFWEC_CMD_WRITE;
                cmd_addr <= {1'b0, store_addr};
                cmd_data <= store_data;
            end
            else if (mass_go || page_go)
            begin
                cmd_kind <= mass_go ? efwec_pkg::EFWEC_CMD_MASS : efwec_pkg::EFWEC_CMD_PAGE;
                cmd_addr <= page_base;
                cmd_data <= efwec_pkg::ERASED_BYTE;
            end
            if (store_now || mass_go || page_go || (busy_fell && posted_write_pending))
                cmd_valid <= 1'b1;
            else if (seq_accept)
                cmd_valid <= 1'b0;
        end
    end

    // Data RAM path and register reads
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            data_ram_wr <= 1'b0;
            data_ram_addr <= 16'h0000;
            data_ram_wdata <= 8'h00;
            sfr_rdata <= 8'h00;
            cfg_rdata <= 8'h00;
        end
        else
        begin
            data_ram_wr <= store_ram;
            data_ram_addr <= store_addr;
            data_ram_wdata <= store_data;
            sfr_rdata <= !sfr_rd ? 8'h00 :
                sfr_addr == efwec_pkg::ADDR_FLASH_CTRL ?
                    {4'h0, posted_write_pending, 1'b0, mass_erase_enable, flash_write_select} :
                sfr_addr == efwec_pkg::ADDR_ERASE_PAGE ? {erase_page_number, 2'h0} : 8'h00;
            cfg_rdata <= !cfg_rd ? 8'h00 :
                cfg_addr == efwec_pkg::ADDR_WRITE_UNLOCK ? {write_unlock_key, 4'h0} :
                cfg_addr == efwec_pkg::ADDR_ENGINE_CODE_LOC ? {1'b0, engine_code_location} :
                cfg_addr == efwec_pkg::ADDR_ENGINE_ENABLE ? {7'h00, engine_enable} : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flash port arbitration
    efwec_flash_arbiter u_arbiter (
        .clock(clock),
        .reset_n(reset_n),
        .spi_ok(special_flash_mode && mpu_halted),
        .key_ok(key_ok),
        .spi_rd(spi_rd),
        .spi_wr(spi_wr),
        .spi_erase(spi_erase),
        .spi_erase_all(spi_erase_all),
        .spi_addr(spi_addr),
        .spi_wdata(spi_wdata),
        .seq_valid(cmd_valid),
        .seq_kind(cmd_kind),
        .seq_addr(cmd_addr),
        .seq_wdata(cmd_data),
        .flash_busy(flash_busy),
        .ce_rd(ce_rd),
        .ce_addr(ce_addr),
        .mpu_rd(mpu_rd),
        .mpu_addr({1'b0, mpu_rd_addr}),
        .seq_accept(seq_accept),
        .fl_addr(flash_addr),
        .fl_wdata(flash_wdata),
        .fl_rd(flash_rd),
        .fl_wr(flash_wr),
        .fl_page_erase(flash_page_erase),
        .fl_mass_erase(flash_mass_erase),
        .fl_owner(flash_owner)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_bad_key_blocks;
        @(posedge clock) disable iff (!reset_n)
        !key_ok |-> !store_take && !mass_go && !page_go;
    endproperty
    a_bad_key_blocks: assert property (p_bad_key_blocks)
        else $error("Flash modify without unlock key");

    property p_select_clears;
        @(posedge clock) disable iff (!reset_n)
        store_flash |=> !flash_write_select;
    endproperty
    a_select_clears: assert property (p_select_clears)
        else $error("Select bit not cleared after flash store");

    property p_select_locked;
        @(posedge clock) disable iff (!reset_n)
        wr_ctrl && interrupts_enabled && !store_flash |=> $stable(flash_write_select);
    endproperty
    a_select_locked: assert property (p_select_locked)
        else $error("Select bit changed with interrupts enabled");

    property p_post_sets_pending;
        @(posedge clock) disable iff (!reset_n)
        store_post |=> posted_write_pending && !cmd_valid;
    endproperty
    a_post_sets_pending: assert property (p_post_sets_pending)
        else $error("Posted write not held pending");

    property p_fall_releases;
        @(posedge clock) disable iff (!reset_n)
        busy_fell && posted_write_pending |=> !posted_write_pending && cmd_valid;
    endproperty
    a_fall_releases: assert property (p_fall_releases)
        else $error("Held write not released on busy fall");

    property p_pending_discards;
        @(posedge clock) disable iff (!reset_n)
        posted_write_pending |-> !store_take;
    endproperty
    a_pending_discards: assert property (p_pending_discards)
        else $error("Flash write taken while pending");

    property p_mass_needs_port;
        @(posedge clock) disable iff (!reset_n)
        mass_go |-> emulation_port && mass_erase_enable && !engine_enable;
    endproperty
    a_mass_needs_port: assert property (p_mass_needs_port)
        else $error("Mass erase without emulation port");

    property p_seq_erase_issue;
        @(posedge clock) disable iff (!reset_n)
        page_go && !special_flash_mode ##1 !flash_busy |=> flash_page_erase;
    endproperty
    a_seq_erase_issue: assert property (p_seq_erase_issue)
        else $error("Page erase not issued");

    property p_erase_exclusive;
        @(posedge clock) disable iff (!reset_n)
        cmd_valid |-> !mass_go && !page_go;
    endproperty
    a_erase_exclusive: assert property (p_erase_exclusive)
        else $error("Erase accepted while one is outstanding");

endmodule : efwec_flash_control

/* File: efwec_flash_model.sv */
`timescale 1ns/1ns
// Flash macro stand-in
module efwec_flash_model #(
    parameter int WR_CYC = 3,
    parameter int ER_CYC = 20
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [16:0] flash_addr,
    input wire logic [7:0] flash_wdata,
    input wire logic flash_wr,
    input wire logic flash_page_erase,
    input wire logic flash_mass_erase,
    input wire logic [16:0] peek_addr,
    output logic flash_busy,
    output logic [7:0] peek_data
);
    logic [7:0] mem [0:131071];
    int cnt;

    ////////////////////////////////////////////////////////////////////////////////
    // Busy and back door
    assign flash_busy = (cnt != 0);
    assign peek_data = mem[peek_addr];

    // Blank array at start
    initial
        for (int i = 0; i < 131072; i++)
            mem[i] = 8'hff;

    // Program clears bits, erase sets ones
    always @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            cnt <= 0;
        else
        begin
            if (cnt != 0)
                cnt <= cnt - 1;
            if (flash_wr)
            begin
                mem[flash_addr] <= mem[flash_addr] & flash_wdata;
                cnt <= WR_CYC;
            end
            if (flash_page_erase)
            begin
                for (int i = 0; i < 1024; i++)
                    mem[{flash_addr[16:10], 10'(i)}] <= 8'hff;
                cnt <= ER_CYC;
            end
            if (flash_mass_erase)
            begin
                for (int i = 0; i < 131072; i++)
                    mem[i] <= 8'hff;
                cnt <= ER_CYC;
            end
        end
    end
endmodule : efwec_flash_model

/* File: embedded_flash_write_erase_control_tb.sv */
`timescale 1ns/1ns
module embedded_flash_write_erase_control_tb;
    logic clock, reset_n, large_variant, sfr_wr, sfr_rd, cfg_wr, cfg_rd, interrupts_enabled;
    logic store_wr, engine_busy, ce_rd, mpu_rd, emulation_port, special_flash_mode, mpu_halted;
    logic spi_rd, spi_wr, spi_erase, spi_erase_all, flash_busy, data_ram_wr, flash_rd, flash_wr;
    logic flash_page_erase, flash_mass_erase, engine_enable;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, cfg_wdata, cfg_rdata, store_data, spi_wdata;
    logic [7:0] data_ram_wdata, flash_wdata, peek_data, d;
    logic [15:0] cfg_addr, store_addr, data_ram_addr, mpu_rd_addr;
    logic [16:0] spi_addr, flash_addr, peek_addr, wr_addr, pe_addr, rd_addr, ram_addr;
    logic [11:0] ce_pc;
    logic [1:0] flash_owner, wr_owner, rd_owner;
    int err_total, comparisons, n_wr, n_pe, n_me, n_spi, n_ram, cyc;
    localparam logic [7:0] CTRL = efwec_pkg::ADDR_FLASH_CTRL, PAGE = efwec_pkg::ADDR_ERASE_PAGE;
    localparam logic [7:0] TRIG = efwec_pkg::ADDR_ERASE_TRIGGER;
    localparam logic [15:0] KEY = efwec_pkg::ADDR_WRITE_UNLOCK, LOC = efwec_pkg::ADDR_ENGINE_CODE_LOC;

    efwec_flash_control u_dut (.clock, .reset_n, .large_variant, .sfr_addr, .sfr_wdata,
        .sfr_wr, .sfr_rd, .sfr_rdata, .cfg_addr, .cfg_wdata, .cfg_wr, .cfg_rd, .cfg_rdata,
        .interrupts_enabled, .store_wr, .store_addr, .store_data, .data_ram_wr, .data_ram_addr,
        .data_ram_wdata, .engine_busy, .ce_rd, .ce_pc, .mpu_rd, .mpu_rd_addr, .emulation_port,
        .special_flash_mode, .mpu_halted, .spi_rd, .spi_wr, .spi_erase, .spi_erase_all,
        .spi_addr, .spi_wdata, .flash_busy, .flash_addr, .flash_wdata, .flash_rd, .flash_wr,
        .flash_page_erase, .flash_mass_erase, .flash_owner, .engine_enable);
    efwec_flash_model u_flash (.clock, .reset_n, .flash_addr, .flash_wdata, .flash_wr,
        .flash_page_erase, .flash_mass_erase, .peek_addr, .flash_busy, .peek_data);

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, timeout, monitor
    initial
    begin
        clock = 0;
        forever #2 clock = ~clock;
    end
    always @(negedge clock)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_total++;
            end_sim();
        end
        if (reset_n === 1'b1)
        begin
            if (flash_wr === 1'b1)
            begin
                n_wr++;
                wr_addr = flash_addr;
                wr_owner = flash_owner;
            end
            if (flash_page_erase === 1'b1)
            begin
                n_pe++;
                pe_addr = flash_addr;
            end
            if (flash_mass_erase === 1'b1)
                n_me++;
            if (flash_rd === 1'b1)
            begin
                rd_addr = flash_addr;
                rd_owner = flash_owner;
                if (flash_owner === efwec_pkg::OWN_SPI)
                    n_spi++;
            end
            if (data_ram_wr === 1'b1)
            begin
                n_ram++;
                ram_addr = {1'b0, data_ram_addr};
                d = data_ram_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus and check tasks
    task idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : idle
    task sfr_w(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock); #1;
        sfr_addr = a; sfr_wdata = v; sfr_wr = 1;
        @(posedge clock); #1;
        sfr_wr = 0;
    endtask : sfr_w
    task sfr_r(input logic [7:0] a);
        @(posedge clock); #1;
        sfr_addr = a; sfr_rd = 1;
        @(posedge clock); #1;
        sfr_rd = 0; d = sfr_rdata;
    endtask : sfr_r
    task cfg_w(input logic [15:0] a, input logic [7:0] v);
        @(posedge clock); #1;
        cfg_addr = a; cfg_wdata = v; cfg_wr = 1;
        @(posedge clock); #1;
        cfg_wr = 0;
    endtask : cfg_w
    task cfg_r(input logic [15:0] a);
        @(posedge clock); #1;
        cfg_addr = a; cfg_rd = 1;
        @(posedge clock); #1;
        cfg_rd = 0; d = cfg_rdata;
    endtask : cfg_r
    task store(input logic [15:0] a, input logic [7:0] v);
        @(posedge clock); #1;
        store_addr = a; store_data = v; store_wr = 1;
        @(posedge clock); #1;
        store_wr = 0;
    endtask : store
    task fetch(input logic [11:0] pc);
        @(posedge clock); #1;
        ce_pc = pc; ce_rd = 1;
        @(posedge clock); #1;
        ce_rd = 0;
        idle(2);
    endtask : fetch
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
            err_total++;
        end
    endtask : check
    task peek(input logic [16:0] a, input logic [7:0] exp);
        peek_addr = a;
        #1;
        check(peek_data, exp);
    endtask : peek
    task end_sim;
        $display("comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task t_locked;
        sfr_r(CTRL); check(d, 8'h0);
        cfg_r(KEY); check(d, 8'h0);
        sfr_w(CTRL, 8'h01); store(16'h1234, 8'h5a); idle(6);
        check(n_wr, 8'h0);
        cfg_w(KEY, 8'h30);
        sfr_w(CTRL, 8'h01); store(16'h1234, 8'h5a); idle(6);
        check(n_wr, 8'h0);
        peek(17'h01234, 8'hff);
        $display("test locked done");
    endtask : t_locked
    task t_write;
        cfg_w(KEY, 8'h20);
        interrupts_enabled = 1;
        sfr_w(CTRL, 8'h01); sfr_r(CTRL);
        check(d, 8'h00);
        interrupts_enabled = 0;
        sfr_w(CTRL, 8'h01); sfr_r(CTRL);
        check(d, 8'h01);
        store(16'h1234, 8'h5a); idle(4);
        check(n_wr, 8'h1);
        check(wr_addr, 17'h01234);
        check(wr_owner, efwec_pkg::OWN_SEQ);
        peek(17'h01234, 8'h5a);
        sfr_r(CTRL); check(d, 8'h00);
        store(16'h0042, 8'h77); idle(3);
        check(n_ram, 8'h1);
        check(d, 8'h77);
        check(ram_addr, 17'h00042);
        check(n_wr, 8'h1);
        $display("test write done");
    endtask : t_write
    task t_posted;
        cfg_w(efwec_pkg::ADDR_ENGINE_ENABLE, 8'h01); engine_busy = 1;
        check(engine_enable, 8'h1);
        sfr_w(CTRL, 8'h01); store(16'h0100, 8'h3c); idle(2);
        sfr_r(CTRL); check(d, 8'h08);
        sfr_w(CTRL, 8'h01); store(16'h0101, 8'h00); idle(3);
        check(n_wr, 8'h1);
        engine_busy = 0; idle(4);
        check(n_wr, 8'h2);
        check(wr_addr, 17'h00100);
        sfr_r(CTRL); check(d, 8'h00);
        peek(17'h00100, 8'h3c); peek(17'h00101, 8'hff);
        cfg_w(efwec_pkg::ADDR_ENGINE_ENABLE, 8'h00);
        $display("test posted done");
    endtask : t_posted
    task t_erase;
        sfr_w(PAGE, 8'h10); sfr_w(TRIG, 8'h5a);
        idle(4); check(n_pe, 8'h0);
        sfr_w(PAGE, 8'h10); sfr_w(TRIG, 8'h55);
        idle(3); check(n_pe, 8'h1);
        check(pe_addr, 17'h01000);
        sfr_w(PAGE, 8'h10); sfr_w(TRIG, 8'h55);
        idle(30); check(n_pe, 8'h1);
        peek(17'h01234, 8'hff); peek(17'h00100, 8'h3c);
        sfr_w(CTRL, 8'h02); sfr_w(TRIG, 8'haa);
        idle(4); check(n_me, 8'h0);
        emulation_port = 1;
        sfr_w(CTRL, 8'h02); sfr_w(TRIG, 8'haa);
        idle(4); check(n_me, 8'h1);
        idle(30); peek(17'h00100, 8'hff);
        $display("test erase done");
    endtask : t_erase
    task t_access;
        cfg_w(LOC, 8'h7f); cfg_r(LOC);
        check(d, 8'h3f);
        large_variant = 1;
        cfg_w(LOC, 8'h7f); cfg_r(LOC);
        check(d, 8'h7f);
        cfg_w(LOC, 8'h05);
        fetch(12'h000); check(rd_addr, 17'h01400);
        check(rd_owner, efwec_pkg::OWN_ENGINE);
        fetch(12'hfff); check(rd_addr, 17'h033fe);
        mpu_rd_addr = 16'hbeef; mpu_rd = 1; idle(1); mpu_rd = 0; idle(2);
        check(rd_addr, 17'h0beef);
        spi_addr = 17'h1abcd; spi_rd = 1; idle(3);
        special_flash_mode = 1; idle(3); check(n_spi, 8'h0);
        mpu_halted = 1; idle(3); check(n_spi != 0, 1'b1);
        check(rd_addr, 17'h1abcd);
        spi_rd = 0;
        $display("test access done");
    endtask : t_access

    // Main sequence
    initial
    begin
        {reset_n, large_variant, sfr_wr, sfr_rd, cfg_wr, cfg_rd, interrupts_enabled} = 0;
        {store_wr, engine_busy, ce_rd, mpu_rd, emulation_port, special_flash_mode} = 0;
        {mpu_halted, spi_rd, spi_wr, spi_erase, spi_erase_all} = 0;
        {sfr_addr, sfr_wdata, cfg_wdata, store_data, spi_wdata, cfg_addr, store_addr} = 0;
        {mpu_rd_addr, spi_addr, peek_addr, ce_pc} = 0;
        repeat (8) @(posedge clock);
        #1 reset_n = 1;
        t_locked();
        t_write();
        t_posted();
        t_erase();
        t_access();
        end_sim();
    end
endmodule : embedded_flash_write_erase_control_tb
